// ### nfp_cfg.svh
// Register indices, field positions and reset values of the NCO/PLL bank
`ifndef NFP_CFG_SVH
`define NFP_CFG_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define NFP_IDX_PHADJ_AB    8'h12
`define NFP_IDX_PHADJ_CD    8'h13
`define NFP_IDX_FREQ_AB_LO  8'h14
`define NFP_IDX_FREQ_AB_HI  8'h15
`define NFP_IDX_FREQ_CD_LO  8'h16
`define NFP_IDX_FREQ_CD_HI  8'h17
`define NFP_IDX_MULT_CTL    8'h18
`define NFP_IDX_MULT_DIV    8'h19
`define NFP_IDX_LOAD_CTL    8'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define NFP_CTL_DISCHARGE   12
`define NFP_CTL_NSYNC_EN    11
`define NFP_CTL_PLL_EN      10
`define NFP_CTL_PUMP_HI     7
`define NFP_CTL_PUMP_LO     6
`define NFP_CTL_PRE_HI      5
`define NFP_CTL_PRE_LO      3
`define NFP_DIV_M_HI        15
`define NFP_DIV_M_LO        8
`define NFP_DIV_N_HI        7
`define NFP_DIV_N_LO        4
`define NFP_DIV_BIAS_HI     3
`define NFP_DIV_BIAS_LO     2
`define NFP_LOAD_AB_BIT     0
`define NFP_LOAD_CD_BIT     1

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define NFP_RST_WORD        16'h0000
`define NFP_RST_MULT_CTL    16'h2808
`define NFP_RST_MULT_DIV    16'h0440
`define NFP_RST_LOAD_CTL    2'h3
`define NFP_M_MIN           7'h04
`define NFP_RESP_OKAY       2'h0
`define NFP_RESP_SLVERR     2'h2

`endif

// ### nfp_nco_acc.sv
// Oscillator accumulator with double-buffered frequency and phase offset
module nfp_nco_acc (
	// Clock and reset
	input wire logic  core_clk,
	input wire logic  rstn,
	// Settings in, phase out
	nfp_nco_if.core   nco
);

	nfp_pkg::nfp_nco_state_t s;
	nfp_pkg::nfp_nco_state_t n;

	// Next state of accumulator and active settings
	always_comb begin
		n = s;
		// RL17 RL18: atomic settings load
		if (nco.load) begin
			n.freq = nco.freqWord;
			n.adj  = nco.phaseAdjust;
		end
		// RL19: wrapping accumulation
		n.acc = s.acc + s.freq;  // Carry out drops: modulo 2^32
		// RL16: upper sixteen bits only
		n.phase = s.acc[31:16] + s.adj;
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign nco.phase      = s.phase;
	// RL3: word is signed two's complement
	assign nco.activeFreq = s.freq;

endmodule : nfp_nco_acc

// ### nfp_nco_if.sv
// Carrier between the register bank and one oscillator accumulator
interface nfp_nco_if;
	logic [31:0] freqWord;
	logic [15:0] phaseAdjust;
	logic        load;
	logic [15:0] phase;
	logic [31:0] activeFreq;

	modport ctrl (output freqWord, output phaseAdjust, output load,
		input phase, input activeFreq);
	modport core (input freqWord, input phaseAdjust, input load,
		output phase, output activeFreq);
endinterface : nfp_nco_if

// ### nfp_pkg.sv
// Types shared by the NCO/PLL configuration bank
package nfp_pkg;

	// Charge pump selection codes
	typedef enum logic [1:0] {
		NFP_PUMP_NONE   = 2'b00,
		NFP_PUMP_SINGLE = 2'b01,
		NFP_PUMP_UNUSED = 2'b10,
		NFP_PUMP_DUAL   = 2'b11
	} nfp_pump_t;

	// Whole state of the register bank and its bus slave
	typedef struct packed {
		logic        awFull;
		logic [7:0]  awIdx;
		logic        wFull;
		logic [15:0] wData;
		logic [1:0]  wStrb;
		logic        bValid;
		logic [1:0]  bResp;
		logic        rValid;
		logic [31:0] rData;
		logic [1:0]  rResp;
		logic [15:0] freqAbLo;
		logic [15:0] freqAbHi;
		logic [15:0] freqCdLo;
		logic [15:0] freqCdHi;
		logic [15:0] phAdjAb;
		logic [15:0] phAdjCd;
		logic [15:0] multCtl;
		logic [15:0] multDiv;
		logic [1:0]  loadCtl;
		logic        loadAb;
		logic        loadCd;
		logic        nDivSync;
	} nfp_state_t;

	// Whole state of one oscillator accumulator
	typedef struct packed {
		logic [31:0] acc;
		logic [31:0] freq;
		logic [15:0] adj;
		logic [15:0] phase;
	} nfp_nco_state_t;

endpackage : nfp_pkg

// ### nfp_regs.sv
// NCO frequency and clock multiplier configuration bank on AXI4-Lite
//
// What this block does
// RL1: AB frequency word low half at 0x14, high half at 0x15.
// RL2: CD frequency word low half at 0x16, high half at 0x17.
// RL3: Frequency words are signed; one step is Fs over 2^32.
// RL4: Discharge bit 12 set pulls loop filter to zero volts.
// RL5: Software restarts a locked-up PLL by toggling discharge one-zero.
// RL6: Bit 11 set lets the LVDS sync align PLL N dividers.
// RL7: Bit 10 set runs clock through PLL; clear bypasses it.
// RL8: Pump field 7:6 decodes none, single, unused, dual.
// RL9: Prescaler field 5:3 gives 2 to 7, code 000 gives 8.
// RL10: Read-only bits 2:0 report loop filter voltage, 0.4125 V steps.
// RL11: Software tunes VCO so reported code stays 010 to 101.
// RL12: M top bit zero divides by low seven bits, 4 to 127.
// RL13: M top bit one divides by twice low bits, 8 to 254.
// RL14: N field 7:4 divides by code plus one.
// RL15: Software sets VCO bias field 3:2 to 01 for normal use.
// RL16: Upper sixteen accumulator bits plus offset feed the lookup.
// RL17: AB halves take effect only when AB phase offset written; with load control bit 0 clear they act at once.
// RL18: CD halves take effect only when CD phase offset written; with load control bit 1 clear they act at once.
// RL19: Accumulators add their frequency word each clock, wrapping.
`include "nfp_cfg.svh"

module nfp_regs (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rstn,
	// AXI4-Lite write address
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	// AXI4-Lite write response
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	output logic [1:0]                  s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	input  wire logic [31:0]            s_axi_araddr,
	// AXI4-Lite read data
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	// Analogue status and sync in
	input  wire logic [2:0]             loopFilterLevel,
	input  wire logic                   lvdsSync,
	// Multiplier controls out
	output logic                        loopFilterDischarge,
	output logic                        nDividerSync,
	output logic                        pllEnable,
	output logic                        pllBypass,
	output nfp_pkg::nfp_pump_t          chargePumpSelect,
	output logic [1:0]                  pumpCount,
	output logic [3:0]                  prescaleDivide,
	output logic                        prescaleValid,
	output logic [7:0]                  mDivide,
	output logic                        mValid,
	output logic [4:0]                  nDivide,
	output logic [1:0]                  vcoBiasTune,
	// Oscillator outputs
	output logic [15:0]                 phaseAb,
	output logic [15:0]                 phaseCd,
	output logic [31:0]                 activeFreqAb,
	output logic [31:0]                 activeFreqCd
);

	// ****************************************************************
	// State and local signals
	// ****************************************************************
	nfp_pkg::nfp_state_t s;
	nfp_pkg::nfp_state_t n;

	logic       awHs;
	logic       wHs;
	logic       haveAw;
	logic       haveW;
	logic       doWrite;
	logic [7:0] wrIdx;
	logic [15:0] wrData;
	logic [1:0] wrStrb;
	logic [7:0] rdIdx;
	logic       wrHit;

	nfp_nco_if ncoAb ();
	nfp_nco_if ncoCd ();

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// Byte-lane merge of a write into a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] data, input logic [1:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = data[7:0];
		end
		if (strb[1]) begin
			r[15:8] = data[15:8];
		end
		return r;
	endfunction : merge16

	// Index decode: true for every mapped register
	function automatic logic mapped(input logic [7:0] idx);
		logic r;
		case (idx)
			`NFP_IDX_PHADJ_AB,
			`NFP_IDX_PHADJ_CD,
			`NFP_IDX_FREQ_AB_LO,
			`NFP_IDX_FREQ_AB_HI,
			`NFP_IDX_FREQ_CD_LO,
			`NFP_IDX_FREQ_CD_HI,
			`NFP_IDX_MULT_CTL,
			`NFP_IDX_MULT_DIV,
			`NFP_IDX_LOAD_CTL: r = 1'b1;
			default:           r = 1'b0;
		endcase
		return r;
	endfunction : mapped

	// ****************************************************************
	// Bus handshakes
	// ****************************************************************

	// One write at a time: address and data stall while a response waits
	assign s_axi_awready = !s.awFull && !s.bValid;
	assign s_axi_wready  = !s.wFull && !s.bValid;
	assign s_axi_arready = !s.rValid;

	assign awHs   = s_axi_awvalid && s_axi_awready;
	assign wHs    = s_axi_wvalid && s_axi_wready;
	assign haveAw = s.awFull || awHs;
	assign haveW  = s.wFull || wHs;
	assign doWrite = haveAw && haveW && !s.bValid;

	// Take the halves from the holding flops or straight from the bus
	assign wrIdx  = s.awFull ? s.awIdx : s_axi_awaddr[9:2];
	assign wrData = s.wFull ? s.wData : s_axi_wdata[15:0];
	assign wrStrb = s.wFull ? s.wStrb : s_axi_wstrb[1:0];
	assign rdIdx  = s_axi_araddr[9:2];
	assign wrHit  = mapped(wrIdx);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		n = s;

		// Hold an address or data that arrives alone
		if (awHs && !doWrite) begin
			n.awFull = 1'b1;
			n.awIdx  = s_axi_awaddr[9:2];
		end
		if (wHs && !doWrite) begin
			n.wFull = 1'b1;
			n.wData = s_axi_wdata[15:0];
			n.wStrb = s_axi_wstrb[1:0];
		end

		// Response retires when the master takes it
		if (s.bValid && s_axi_bready) begin
			n.bValid = 1'b0;
		end

		// Default: no settings load this cycle unless loads are open
		n.loadAb = !s.loadCtl[`NFP_LOAD_AB_BIT];
		n.loadCd = !s.loadCtl[`NFP_LOAD_CD_BIT];

		// Register write
		if (doWrite) begin
			n.awFull = 1'b0;
			n.wFull  = 1'b0;
			n.bValid = 1'b1;
			n.bResp  = wrHit ? `NFP_RESP_OKAY : `NFP_RESP_SLVERR;
			case (wrIdx)
				// RL1: AB word halves
				`NFP_IDX_FREQ_AB_LO: begin
					n.freqAbLo = merge16(s.freqAbLo, wrData, wrStrb);
				end
				`NFP_IDX_FREQ_AB_HI: begin
					n.freqAbHi = merge16(s.freqAbHi, wrData, wrStrb);
				end
				// RL2: CD word halves
				`NFP_IDX_FREQ_CD_LO: begin
					n.freqCdLo = merge16(s.freqCdLo, wrData, wrStrb);
				end
				`NFP_IDX_FREQ_CD_HI: begin
					n.freqCdHi = merge16(s.freqCdHi, wrData, wrStrb);
				end
				// RL17: offset write releases AB load
				`NFP_IDX_PHADJ_AB: begin
					n.phAdjAb = merge16(s.phAdjAb, wrData, wrStrb);
					n.loadAb  = 1'b1;
				end
				// RL18: offset write releases CD load
				`NFP_IDX_PHADJ_CD: begin
					n.phAdjCd = merge16(s.phAdjCd, wrData, wrStrb);
					n.loadCd  = 1'b1;
				end
				// RL10: low three bits are not stored
				`NFP_IDX_MULT_CTL: begin
					n.multCtl = merge16(s.multCtl, wrData, wrStrb);
					n.multCtl[2:0] = 3'h0;
				end
				`NFP_IDX_MULT_DIV: begin
					n.multDiv = merge16(s.multDiv, wrData, wrStrb);
				end
				`NFP_IDX_LOAD_CTL: begin
					if (wrStrb[0]) begin
						n.loadCtl = wrData[1:0];
					end
				end
				default: begin
					n.bResp = `NFP_RESP_SLVERR;
				end
			endcase
		end

		// Read: answer one cycle after the address is taken
		if (s.rValid && s_axi_rready) begin
			n.rValid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			n.rValid = 1'b1;
			n.rResp  = `NFP_RESP_OKAY;
			n.rData  = 32'h0000_0000;
			case (rdIdx)
				`NFP_IDX_PHADJ_AB:   n.rData[15:0] = s.phAdjAb;
				`NFP_IDX_PHADJ_CD:   n.rData[15:0] = s.phAdjCd;
				`NFP_IDX_FREQ_AB_LO: n.rData[15:0] = s.freqAbLo;
				`NFP_IDX_FREQ_AB_HI: n.rData[15:0] = s.freqAbHi;
				`NFP_IDX_FREQ_CD_LO: n.rData[15:0] = s.freqCdLo;
				`NFP_IDX_FREQ_CD_HI: n.rData[15:0] = s.freqCdHi;
				// RL10: live loop filter level
				`NFP_IDX_MULT_CTL: begin
					n.rData[15:0] = {s.multCtl[15:3], loopFilterLevel};
				end
				`NFP_IDX_MULT_DIV:   n.rData[15:0] = s.multDiv;
				`NFP_IDX_LOAD_CTL:   n.rData[1:0]  = s.loadCtl;
				default: begin
					n.rResp = `NFP_RESP_SLVERR;
				end
			endcase
		end

		// RL6: sync gated by enable
		n.nDivSync = lvdsSync && s.multCtl[`NFP_CTL_NSYNC_EN];
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s          <= '0;
			s.freqAbLo <= `NFP_RST_WORD;
			s.freqAbHi <= `NFP_RST_WORD;
			s.freqCdLo <= `NFP_RST_WORD;
			s.freqCdHi <= `NFP_RST_WORD;
			s.phAdjAb  <= `NFP_RST_WORD;
			s.phAdjCd  <= `NFP_RST_WORD;
			s.multCtl  <= `NFP_RST_MULT_CTL;
			s.multDiv  <= `NFP_RST_MULT_DIV;
			s.loadCtl  <= `NFP_RST_LOAD_CTL;
		end else begin
			s <= n;
		end
	end

	// ****************************************************************
	// Bus outputs
	// ****************************************************************
	assign s_axi_bvalid = s.bValid;
	assign s_axi_bresp  = s.bResp;
	assign s_axi_rvalid = s.rValid;
	assign s_axi_rdata  = s.rData;
	assign s_axi_rresp  = s.rResp;

	// ****************************************************************
	// Multiplier control decode
	// ****************************************************************

	// RL4: discharge level
	assign loopFilterDischarge = s.multCtl[`NFP_CTL_DISCHARGE];
	assign nDividerSync        = s.nDivSync;

	// RL7: enable or bypass
	assign pllEnable = s.multCtl[`NFP_CTL_PLL_EN];
	assign pllBypass = !s.multCtl[`NFP_CTL_PLL_EN];

	// RL8: charge pump decode
	always_comb begin
		chargePumpSelect = nfp_pkg::nfp_pump_t'(
			s.multCtl[`NFP_CTL_PUMP_HI:`NFP_CTL_PUMP_LO]);
		case (chargePumpSelect)
			nfp_pkg::NFP_PUMP_SINGLE: pumpCount = 2'h1;
			nfp_pkg::NFP_PUMP_DUAL:   pumpCount = 2'h2;
			default:                  pumpCount = 2'h0;  // Unused as none
		endcase
	end

	// RL9: prescaler decode, code 001 has no ratio
	always_comb begin
		case (s.multCtl[`NFP_CTL_PRE_HI:`NFP_CTL_PRE_LO])
			3'h0: begin
				prescaleDivide = 4'h8;
				prescaleValid  = 1'b1;
			end
			3'h1: begin
				prescaleDivide = 4'h0;
				prescaleValid  = 1'b0;
			end
			default: begin
				prescaleDivide = {1'b0,
					s.multCtl[`NFP_CTL_PRE_HI:`NFP_CTL_PRE_LO]};
				prescaleValid  = 1'b1;
			end
		endcase
	end

	// RL12 RL13: M ratio, doubled when top bit set
	always_comb begin
		if (s.multDiv[`NFP_DIV_M_HI]) begin
			mDivide = {s.multDiv[`NFP_DIV_M_HI-1:`NFP_DIV_M_LO], 1'b0};
		end else begin
			mDivide = {1'b0, s.multDiv[`NFP_DIV_M_HI-1:`NFP_DIV_M_LO]};
		end
		// Same floor on the code for both ranges
		mValid = s.multDiv[`NFP_DIV_M_HI-1:`NFP_DIV_M_LO] >= `NFP_M_MIN;
	end

	// RL14: N ratio is code plus one
	assign nDivide = {1'b0, s.multDiv[`NFP_DIV_N_HI:`NFP_DIV_N_LO]} + 5'h01;

	// RL15: bias field passes as written
	assign vcoBiasTune = s.multDiv[`NFP_DIV_BIAS_HI:`NFP_DIV_BIAS_LO];

	// ****************************************************************
	// Oscillators
	// ****************************************************************

	// Shadow words feed the accumulators; they only act on load
	assign ncoAb.freqWord    = {s.freqAbHi, s.freqAbLo};
	assign ncoAb.phaseAdjust = s.phAdjAb;
	assign ncoAb.load        = s.loadAb;
	assign ncoCd.freqWord    = {s.freqCdHi, s.freqCdLo};
	assign ncoCd.phaseAdjust = s.phAdjCd;
	assign ncoCd.load        = s.loadCd;

	// AB path accumulator
	nfp_nco_acc u_nco_ab (
		.core_clk (core_clk),
		.rstn     (rstn),
		.nco      (ncoAb.core)
	);

	// CD path accumulator
	nfp_nco_acc u_nco_cd (
		.core_clk (core_clk),
		.rstn     (rstn),
		.nco      (ncoCd.core)
	);

	assign phaseAb      = ncoAb.phase;
	assign phaseCd      = ncoCd.phase;
	assign activeFreqAb = ncoAb.activeFreq;
	assign activeFreqCd = ncoCd.activeFreq;

endmodule : nfp_regs

// ### nfp_regs_asserts.sv
// Concurrent checks on the ports of the NCO/PLL configuration bank
module nfp_regs_asserts (
	// Clock and reset
	input wire logic               core_clk,
	input wire logic               rstn,
	// Register bus
	input wire logic               s_axi_awvalid,
	input wire logic               s_axi_awready,
	input wire logic               s_axi_wvalid,
	input wire logic               s_axi_wready,
	input wire logic               s_axi_bvalid,
	input wire logic               s_axi_bready,
	input wire logic [1:0]         s_axi_bresp,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire logic               s_axi_rvalid,
	input wire logic [31:0]        s_axi_rdata,
	// Multiplier and oscillator
	input wire logic               lvdsSync,
	input wire logic               nDividerSync,
	input wire logic               pllEnable,
	input wire logic               pllBypass,
	input wire nfp_pkg::nfp_pump_t chargePumpSelect,
	input wire logic [1:0]         pumpCount,
	input wire logic [3:0]         prescaleDivide,
	input wire logic               prescaleValid,
	input wire logic [4:0]         nDivide,
	input wire logic [31:0]        activeFreqAb
);
	timeunit 1ns;
	timeprecision 1ps;

	// One clock domain, so one clocking and one reset for all
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// Handshake steps of the bus
	sequence wrBoth;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rdTake;
		s_axi_arvalid && s_axi_arready;
	endsequence

	// Answers come one cycle after the request is taken
	write_answer_a: assert property (wrBoth |=> s_axi_bvalid)
		else $error("Write not answered next cycle");
	read_answer_a: assert property (rdTake |=> s_axi_rvalid)
		else $error("Read not answered next cycle");
	// A response stands until taken; no new write meanwhile
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped early");
	ready_block_a: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("Write taken during response");
	read_upper_a: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:16] == 16'h0000)
		else $error("Read upper half not zero");
	// Decoded multiplier controls
	sync_delay_a: assert property (nDividerSync |-> $past(lvdsSync))
		else $error("Divider sync without sync input");
	bypass_invert_a: assert property (pllBypass == !pllEnable)
		else $error("Bypass not inverse of enable");
	pump_count_a: assert property (pumpCount ==
		((chargePumpSelect == nfp_pkg::NFP_PUMP_DUAL) ? 2'h2 :
		(chargePumpSelect == nfp_pkg::NFP_PUMP_SINGLE) ? 2'h1 : 2'h0))
		else $error("Pump count wrong for code");
	prescale_range_a: assert property (prescaleValid |->
		prescaleDivide >= 4'h2 && prescaleDivide <= 4'h8)
		else $error("Prescale out of range");
	ndiv_range_a: assert property (nDivide >= 5'h01
		&& nDivide <= 5'h10) else $error("N divide out of range");
	// Active word only moves shortly after a write landed
	freq_load_a: assert property ($changed(activeFreqAb)
		|-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
		else $error("Active word changed without a write");
endmodule : nfp_regs_asserts

// ### nfp_regs_bench.sv
// Self-checking bench for the NCO/PLL configuration bank
`include "nfp_cfg.svh"
module nfp_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ********
	// Signals
	// ********
	logic               core_clk, rstn, lvdsSync, prescaleValid, mValid;
	logic               s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic               s_axi_arvalid, s_axi_rready, s_axi_awready;
	logic               s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic               s_axi_rvalid, loopFilterDischarge, nDividerSync;
	logic               pllEnable, pllBypass;
	logic [31:0]        s_axi_awaddr, s_axi_wdata, s_axi_araddr;
	logic [31:0]        s_axi_rdata, activeFreqAb, activeFreqCd;
	logic [3:0]         s_axi_wstrb, prescaleDivide;
	logic [1:0]         s_axi_bresp, s_axi_rresp, pumpCount, vcoBiasTune;
	logic [2:0]         loopFilterLevel;
	logic [7:0]         mDivide;
	logic [4:0]         nDivide;
	logic [15:0]        phaseAb, phaseCd;
	nfp_pkg::nfp_pump_t chargePumpSelect;
	int                 nErrors, checked;
	logic [7:0]         mCodes [6] = '{8'h04, 8'h7F, 8'h03, 8'h84, 8'hFF, 8'h83};

	nfp_regs nfp_regs_inst (.core_clk, .rstn, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .loopFilterLevel, .lvdsSync,
		.loopFilterDischarge, .nDividerSync, .pllEnable, .pllBypass,
		.chargePumpSelect, .pumpCount, .prescaleDivide, .prescaleValid,
		.mDivide, .mValid, .nDivide, .vcoBiasTune, .phaseAb, .phaseCd,
		.activeFreqAb, .activeFreqCd);

	// ********
	// Bus helpers
	// ********
	// Registers sit one word apart, so the byte address is four times index
	function automatic logic [31:0] ba(input logic [7:0] i);
		return {22'h000000, i, 2'b00};
	endfunction : ba

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		checked++;
		if (got !== exp) begin
			nErrors++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	// Bready may lag by stall cycles so the response has to stand
	task automatic axiWrite(input logic [31:0] a, input logic [15:0] d,
		input int stall, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (stall == 0);
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (n == stall) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		chk({31'h0, n < 50}, 32'h1, "write hang");
	endtask : axiWrite

	task automatic axiRead(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk({31'h0, n < 50}, 32'h1, "read hang");
	endtask : axiRead

	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		logic [1:0] r;
		axiWrite(a, d, 0, r);
		chk({30'h0, r}, 32'h0, "bresp");
	endtask : wr

	task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axiRead(a, d, r);
		chk(d, e, "rdata");
		chk({30'h0, r}, 32'h0, "rresp");
	endtask : rdChk

	// ********
	// Scenarios
	// ********
	task automatic testReset;
		chk({24'h0, pllBypass, vcoBiasTune, nDivide}, 32'h85, "rst out");
		for (int i = 0; i < 4; i++) rdChk(ba(8'h14 + i[7:0]), 32'h0);
		rdChk(ba(`NFP_IDX_MULT_CTL), 32'h280D);
		rdChk(ba(`NFP_IDX_MULT_DIV), 32'h0440);
	endtask : testReset

	// Unmapped place, with a late bready so the answer must stand
	task automatic testUnmapped;
		logic [31:0] d;
		logic [1:0] r;
		axiWrite(ba(8'h1D), 16'hFFFF, 3, r);
		chk({30'h0, r}, 32'h2, "unmapped bresp");
		axiRead(ba(8'h1D), d, r);
		chk({d[29:0], r}, 32'h2, "unmapped read");
	endtask : testUnmapped

	// Every pump and prescale code; discharge toggles one then zero
	task automatic testCtl;
		logic [3:0] pd;
		logic [1:0] pc;
		for (int i = 0; i < 32; i++) begin
			lvdsSync <= i[3];
			loopFilterLevel <= ~i[2:0];
			wr(ba(`NFP_IDX_MULT_CTL), {3'b001, i[0], i[1], i[2], 2'b00, i[4:3],
				i[2:0], 3'b111});
			pc = (i[4:3] == 2'b11) ? 2'h2 : {1'b0, i[4:3] == 2'b01};
			pd = (i[2:0] == 3'h0) ? 4'h8 : (i[2:0] == 3'h1) ? 4'h0 : {1'b0, i[2:0]};
			@(posedge core_clk);
			chk({25'h0, loopFilterDischarge, nDividerSync, pllEnable,
				chargePumpSelect, pumpCount}, {25'h0, i[0], i[3] & i[1], i[2],
				i[4:3], pc}, "ctl");
			chk({27'h0, prescaleValid, prescaleDivide},
				{27'h0, i[2:0] != 3'h1, pd}, "prescale");
			rdChk(ba(`NFP_IDX_MULT_CTL), {16'h0000, 3'b001, i[0], i[1], i[2],
				2'b00, i[4:3], i[2:0], ~i[2:0]});
		end
	endtask : testCtl

	task automatic testDiv;
		logic [7:0] m;
		for (int i = 0; i < 16; i++) begin
			m = mCodes[i % 6];
			wr(ba(`NFP_IDX_MULT_DIV), {m, i[3:0], 4'b0100});
			chk({16'h0, mValid, mDivide, vcoBiasTune, nDivide}, {16'h0,
				m[6:0] >= 7'h04, m[7] ? {m[6:0], 1'b0} : {1'b0, m[6:0]}, 2'b01,
				5'(i + 1)}, "dividers");
			rdChk(ba(`NFP_IDX_MULT_DIV), {16'h0000, m, i[3:0], 4'b0100});
		end
	endtask : testDiv

	// Halves wait for the offset write, then the accumulators step
	task automatic testNco;
		logic [15:0] p;
		wr(ba(`NFP_IDX_FREQ_AB_LO), 16'h8000);
		wr(ba(`NFP_IDX_FREQ_AB_HI), 16'h0003);
		s_axi_wstrb <= 4'h2;
		wr(ba(`NFP_IDX_FREQ_CD_LO), 16'h80AB);
		s_axi_wstrb <= 4'hF;
		wr(ba(`NFP_IDX_FREQ_CD_HI), 16'hFFFE);
		rdChk(ba(`NFP_IDX_FREQ_CD_LO), 32'h8000);
		chk(activeFreqAb | activeFreqCd, 32'h0, "early load");
		wr(ba(`NFP_IDX_PHADJ_AB), 16'h1234);
		repeat (2) @(posedge core_clk);
		chk(activeFreqAb, 32'h00038000, "ab load");
		chk(activeFreqCd, 32'h0, "cd held");
		repeat (2) @(posedge core_clk);
		p = phaseAb;
		repeat (2) @(posedge core_clk);
		chk({16'h0, phaseAb - p}, 32'h7, "ab step");
		wr(ba(`NFP_IDX_PHADJ_CD), 16'h0000);
		repeat (2) @(posedge core_clk);
		chk(activeFreqCd, 32'hFFFE8000, "cd load");
		repeat (2) @(posedge core_clk);
		p = phaseCd;
		repeat (2) @(posedge core_clk);
		chk({16'h0, phaseCd - p}, 32'hFFFD, "cd step");
	endtask : testNco

	// Auto-load off: halves act at once; offset shifts the phase
	task automatic testDirect;
		logic [15:0] p;
		wr(ba(`NFP_IDX_LOAD_CTL), 16'h0000);
		wr(ba(`NFP_IDX_FREQ_AB_HI), 16'h0000);
		wr(ba(`NFP_IDX_FREQ_AB_LO), 16'h0000);
		repeat (2) @(posedge core_clk);
		chk(activeFreqAb, 32'h0, "direct load");
		p = phaseAb;
		wr(ba(`NFP_IDX_PHADJ_AB), 16'h1334);
		repeat (3) @(posedge core_clk);
		chk({16'h0, phaseAb - p}, 32'h0100, "offset step");
		rdChk(ba(`NFP_IDX_LOAD_CTL), 32'h0);
	endtask : testDirect

	task automatic giveVerdict;
		$display("Checks %0d, errors %0d", checked, nErrors);
		if (nErrors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : giveVerdict

	// ********
	// Clock, sequence and watchdog
	// ********
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, lvdsSync, rstn} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hF;
		loopFilterLevel = 3'h5;
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		testReset();
		testUnmapped();
		testCtl();
		testDiv();
		testNco();
		testDirect();
		giveVerdict();
	end

	// Tests need about 400 cycles; over thirty times that marks a hang
	initial begin
		#300us;
		nErrors++;
		giveVerdict();
	end
endmodule : nfp_regs_bench

bind nfp_regs nfp_regs_asserts nfp_regs_asserts_inst (.core_clk, .rstn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .lvdsSync, .nDividerSync,
	.pllEnable, .pllBypass, .chargePumpSelect, .pumpCount, .prescaleDivide,
	.prescaleValid, .nDivide, .activeFreqAb);
